// file: logic/psw_pkg.sv
// Package of constants, types and helpers for the program space data window.
package psw_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int ADDR_W    = 16;
	localparam int PAGE_W    = 8;
	localparam int OFS_W     = 15;
	localparam int PM_ADDR_W = PAGE_W + OFS_W;
	localparam int WORD_W    = 24;
	localparam int DATA_W    = 16;
	localparam int EXTRA_W   = 2;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int                WINDOW_BIT = 15;
	localparam logic [PAGE_W-1:0] PAGE_RST   = 8'h00;

	// ------------------------------------------------------------------
	// Added instruction cycles
	// ------------------------------------------------------------------
	localparam logic [EXTRA_W-1:0] EXTRA_NONE  = 2'h0;
	localparam logic [EXTRA_W-1:0] EXTRA_MOVE  = 2'h1;
	localparam logic [EXTRA_W-1:0] EXTRA_OTHER = 2'h2;
	localparam logic [EXTRA_W-1:0] EXTRA_EDGE  = 2'h2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		PSW_IDLE  = 3'b000,
		PSW_HOLD  = 3'b001,
		PSW_FETCH = 3'b010,
		PSW_CAPT  = 3'b011,
		PSW_EXTRA = 3'b100
	} psw_state_t;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic psw_hit(input logic [ADDR_W-1:0] addr, input logic en);
		return addr[WINDOW_BIT] & en;
	endfunction

endpackage

// file: logic/psw_cost.sv
// Added-cycle calculator for reads that go through the program window.
`timescale 1ns/1ps
module psw_cost
	import psw_pkg::*;
(
	input  wire logic               in_repeat,
	input  wire logic               rep_first,
	input  wire logic               rep_last,
	input  wire logic               rep_int_exit,
	input  wire logic               rep_reentry,
	input  wire logic               is_move,
	output      logic [EXTRA_W-1:0] extra
);

	always_comb begin
		if (in_repeat) begin
			if (rep_first || rep_last || rep_int_exit || rep_reentry) begin
				extra = EXTRA_EDGE;
			end else begin
				extra = EXTRA_NONE;
			end
		end else if (is_move) begin
			extra = EXTRA_MOVE;
		end else begin
			extra = EXTRA_OTHER;
		end
	end

endmodule

// file: logic/psw_window.sv
// Program space data window: maps upper data space reads onto a program page.
`timescale 1ns/1ps
module psw_window
	import psw_pkg::*;
(
	input  wire logic                 CLK,
	input  wire logic                 SYS_RST,
	input  wire logic                 RD_REQ,
	input  wire logic [ADDR_W-1:0]    RD_ADDR,
	input  wire logic                 INSN_MOVE,
	input  wire logic                 REP_ACTIVE,
	input  wire logic                 REP_FIRST,
	input  wire logic                 REP_LAST,
	input  wire logic                 REP_INT_EXIT,
	input  wire logic                 REP_REENTRY,
	input  wire logic                 PROGRAM_WINDOW_ENABLE,
	input  wire logic                 TABLE_BUSY,
	input  wire logic                 PAGE_WR,
	input  wire logic [PAGE_W-1:0]    PAGE_WDATA,
	input  wire logic [WORD_W-1:0]    PM_RDATA,
	output      logic                 RD_READY,
	output      logic                 DM_SEL,
	output      logic                 RD_VALID,
	output      logic [DATA_W-1:0]    RD_DATA,
	output      logic                 STALL,
	output      logic                 PM_REQ,
	output      logic [PM_ADDR_W-1:0] PM_ADDR,
	output      logic [PAGE_W-1:0]    WINDOW_PAGE_SELECT
);

	// ------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------
	psw_state_t         state_q;
	logic [EXTRA_W-1:0] extra_d;
	logic [EXTRA_W-1:0] cnt_q;
	logic [OFS_W-1:0]   ofs_q;
	logic               accept;
	logic               hit;

	assign RD_READY = (state_q == PSW_IDLE);
	assign STALL    = (state_q != PSW_IDLE);
	assign accept   = RD_REQ && RD_READY;
	assign hit      = psw_hit(RD_ADDR, PROGRAM_WINDOW_ENABLE);

	psw_cost u_cost (
		.in_repeat    (REP_ACTIVE),
		.rep_first    (REP_FIRST),
		.rep_last     (REP_LAST),
		.rep_int_exit (REP_INT_EXIT),
		.rep_reentry  (REP_REENTRY),
		.is_move      (INSN_MOVE),
		.extra        (extra_d)
	);

	// ------------------------------------------------------------------
	// Page register
	// ------------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			WINDOW_PAGE_SELECT <= PAGE_RST;
		end else if (PAGE_WR) begin
			WINDOW_PAGE_SELECT <= PAGE_WDATA;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// The page is sampled at fetch time, so a page write during a table
	// hold still steers the pending read.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_q <= PSW_IDLE;
			cnt_q   <= EXTRA_NONE;
			ofs_q   <= '0;
		end else begin
			case (state_q)
				PSW_IDLE: begin
					if (accept && hit) begin
						ofs_q <= RD_ADDR[OFS_W-1:0];
						cnt_q <= extra_d;
						state_q <= TABLE_BUSY ? PSW_HOLD : PSW_FETCH;
					end
				end
				PSW_HOLD: begin
					if (!TABLE_BUSY) begin
						state_q <= PSW_FETCH;
					end
				end
				PSW_FETCH: begin
					state_q <= PSW_CAPT;
				end
				PSW_CAPT: begin
					state_q <= (cnt_q == EXTRA_NONE) ? PSW_IDLE : PSW_EXTRA;
				end
				PSW_EXTRA: begin
					cnt_q <= cnt_q - 2'h1;
					if (cnt_q == 2'h1) begin
						state_q <= PSW_IDLE;
					end
				end
				default: begin
					state_q <= PSW_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Program fetch port
	// ------------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PM_REQ  <= 1'b0;
			PM_ADDR <= '0;
		end else begin
			PM_REQ <= 1'b0;
			if ((state_q == PSW_IDLE && accept && hit && !TABLE_BUSY)
				|| (state_q == PSW_HOLD && !TABLE_BUSY)) begin
				PM_REQ  <= 1'b1;
				PM_ADDR <= {WINDOW_PAGE_SELECT,
					(state_q == PSW_IDLE) ? RD_ADDR[OFS_W-1:0] : ofs_q};
			end
		end
	end

	// ------------------------------------------------------------------
	// Read answer
	// ------------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			RD_DATA  <= '0;
			RD_VALID <= 1'b0;
			DM_SEL   <= 1'b0;
		end else begin
			DM_SEL   <= accept && !hit;
			RD_VALID <= (state_q == PSW_CAPT && cnt_q == EXTRA_NONE)
				|| (state_q == PSW_EXTRA && cnt_q == 2'h1);
			if (state_q == PSW_CAPT) begin
				RD_DATA <= PM_RDATA[DATA_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	logic go;
	assign go = accept && hit && !TABLE_BUSY;

	sequence s_done_after_3;
		!RD_VALID ##1 !RD_VALID ##1 RD_VALID;
	endsequence

	sequence s_done_after_4;
		!RD_VALID [*3] ##1 RD_VALID;
	endsequence

	sequence s_done_after_5;
		!RD_VALID [*4] ##1 RD_VALID;
	endsequence

	property p_plain_read;
		accept && !hit |=> DM_SEL && !STALL && !PM_REQ;
	endproperty
	a_plain_read: assert property (p_plain_read) else $error("plain read not sent to data memory");

	property p_window_read;
		accept && hit |=> !DM_SEL && STALL;
	endproperty
	a_window_read: assert property (p_window_read) else $error("window read not redirected");

	property p_addr_compose;
		go |=> PM_REQ && PM_ADDR == {$past(WINDOW_PAGE_SELECT), $past(RD_ADDR[OFS_W-1:0])};
	endproperty
	a_addr_compose: assert property (p_addr_compose) else $error("program address wrong");

	property p_move_cost;
		go && !REP_ACTIVE && INSN_MOVE |-> ##1 s_done_after_4;
	endproperty
	a_move_cost: assert property (p_move_cost) else $error("move did not add one cycle");

	property p_other_cost;
		go && !REP_ACTIVE && !INSN_MOVE |-> ##1 s_done_after_5;
	endproperty
	a_other_cost: assert property (p_other_cost) else $error("other did not add two cycles");

	property p_repeat_mid;
		go && REP_ACTIVE && !(REP_FIRST || REP_LAST || REP_INT_EXIT || REP_REENTRY)
			|-> ##1 s_done_after_3;
	endproperty
	a_repeat_mid: assert property (p_repeat_mid) else $error("repeat body added cycles");

	property p_repeat_edge;
		go && REP_ACTIVE && (REP_FIRST || REP_LAST || REP_INT_EXIT || REP_REENTRY)
			|-> ##1 s_done_after_5;
	endproperty
	a_repeat_edge: assert property (p_repeat_edge) else $error("repeat edge cost wrong");

	property p_table_hold;
		$past(TABLE_BUSY) |-> !PM_REQ;
	endproperty
	a_table_hold: assert property (p_table_hold) else $error("fetch during table op");

	property p_low_word;
		PM_REQ |=> ##1 RD_DATA == $past(PM_RDATA[DATA_W-1:0]);
	endproperty
	a_low_word: assert property (p_low_word) else $error("returned data not low 16 bits");

	property p_page_write;
		PAGE_WR |=> WINDOW_PAGE_SELECT == $past(PAGE_WDATA);
	endproperty
	a_page_write: assert property (p_page_write) else $error("page register not written");

endmodule

// file: verification/psw_flash_model.sv
// Program flash model that answers window fetches one cycle after each request.
`timescale 1ns/1ps
module psw_flash_model
	import psw_pkg::*;
(
	input  wire logic                 CLK,
	input  wire logic                 PM_REQ,
	input  wire logic [PM_ADDR_W-1:0] PM_ADDR,
	output      logic [WORD_W-1:0]    PM_RDATA
);
	initial PM_RDATA = '0;
	// The upper byte copies address bit 0 into all eight bits, and the low half mixes page and offset.
	always @(posedge CLK) begin
		if (PM_REQ) begin
			PM_RDATA <= {{8{PM_ADDR[0]}}, PM_ADDR[15:0] ^ {2{PM_ADDR[22:15]}}};
		end else begin
			// Outside the answer cycle the bus never repeats a stale word.
			PM_RDATA <= ~PM_RDATA;
		end
	end
endmodule

// file: verification/tb_psw_window.sv
// Self-checking bench for the program space data window.
`timescale 1ns/1ps
module tb_psw_window
	import psw_pkg::*;
;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 req = 1'b0;
	logic                 move = 1'b0;
	logic                 rep = 1'b0;
	logic                 en = 1'b0;
	logic                 busy = 1'b0;
	logic                 pwr = 1'b0;
	logic [3:0]           kind = 4'h0;
	logic [ADDR_W-1:0]    addr = '0;
	logic [PAGE_W-1:0]    pwd = '0;
	logic [WORD_W-1:0]    pm_rdata;
	logic                 rd_ready, dm_sel, rd_valid, stall, pm_req;
	logic [DATA_W-1:0]    rd_data;
	logic [PM_ADDR_W-1:0] pm_addr;
	logic [PAGE_W-1:0]    page_q;
	int                   num_errors = 0;
	int                   n_checks = 0;
	int                   seed = 32'hbce0;
	logic [PAGE_W-1:0]    page = 8'h00;
	logic [DATA_W-1:0]    exp_q[$];

	always #12.5 clk = ~clk;

	psw_window u_dut (.CLK(clk), .SYS_RST(rst), .RD_REQ(req), .RD_ADDR(addr),
		.INSN_MOVE(move), .REP_ACTIVE(rep), .REP_FIRST(kind[0]), .REP_LAST(kind[1]),
		.REP_INT_EXIT(kind[2]), .REP_REENTRY(kind[3]), .PROGRAM_WINDOW_ENABLE(en),
		.TABLE_BUSY(busy), .PAGE_WR(pwr), .PAGE_WDATA(pwd), .PM_RDATA(pm_rdata),
		.RD_READY(rd_ready), .DM_SEL(dm_sel), .RD_VALID(rd_valid), .RD_DATA(rd_data),
		.STALL(stall), .PM_REQ(pm_req), .PM_ADDR(pm_addr), .WINDOW_PAGE_SELECT(page_q));

	psw_flash_model u_flash (.CLK(clk), .PM_REQ(pm_req), .PM_ADDR(pm_addr),
		.PM_RDATA(pm_rdata));

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic set_page(input logic [7:0] v);
		pwr = 1'b1;
		pwd = v;
		@(negedge clk);
		pwr = 1'b0;
		page = v;
		chk("page", 24'(page_q), 24'(v));
	endtask

	// One read; k is the number of cycles a table operation holds the window off.
	task automatic rd(input int k);
		int i, n, last;
		logic hit;
		logic [PM_ADDR_W-1:0] pa;
		hit = addr[WINDOW_BIT] & en;
		n = !hit ? 0 : !rep ? (move ? 1 : 2) : (kind != 4'h0 ? 2 : 0);
		last = hit ? 3 + n + k : 1;
		pa = {page, addr[14:0]};
		busy = hit && k > 0;
		if (hit)
			exp_q.push_back(pa[15:0] ^ {2{pa[22:15]}});
		req = 1'b1;
		chk("ready", 24'(rd_ready), 24'h1);
		@(negedge clk);
		for (i = 1; i <= last + 1; i++) begin
			req = 1'b0;
			if (i == k)
				busy = 1'b0;
			chk("valid", 24'(rd_valid), 24'(hit && i == last));
			chk("dm_sel", 24'(dm_sel), 24'(!hit && i == 1));
			chk("stall", 24'(stall), 24'(hit && i < last));
			chk("ready_busy", 24'(rd_ready), 24'(!(hit && i < last)));
			chk("pm_req", 24'(pm_req), 24'(hit && i == 1 + k));
			if (hit && i == 1 + k)
				chk("pm_addr", 24'(pm_addr), 24'(pa));
			if (hit && i == last)
				chk("data", 24'(rd_data), 24'(exp_q.pop_front()));
			@(negedge clk);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int m;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk("page_rst", 24'(page_q), 24'(PAGE_RST));
		chk("valid_rst", 24'(rd_valid), 24'h0);
		for (int j = 0; j < 80; j++) begin
			if (j % 6 == 0)
				set_page(8'($random(seed)));
			addr = 16'($random(seed));
			addr[15] = (j % 3 != 0);
			if (j == 1)
				addr = 16'h8000;
			if (j == 2)
				addr = 16'hffff;
			en = (j % 7 != 6);
			m = j % 5;
			kind = (m == 0) ? 4'h0 : 4'(1 << (m - 1));
			rep = ((j / 5) % 2) == 1;
			move = ((j / 10) % 2) == 1;
			rd(j % 4 == 3 ? 1 + j % 3 : 0);
		end
		close_out();
	end
endmodule
